// >>> rtl/csm_pkg.sv
// Package: constants, offsets, reset values and types of the scaling and serial setup block
package csm_pkg;

  // ------------------------------------------------------------
  // Register offsets (word index on the plain register port)
  // ------------------------------------------------------------
  localparam logic [7:0] CSM_REG_SET_SEL     = 8'h00;
  localparam logic [7:0] CSM_REG_MUL         = 8'h01;
  localparam logic [7:0] CSM_REG_DEN         = 8'h02;
  localparam logic [7:0] CSM_REG_SHIFT       = 8'h03;
  localparam logic [7:0] CSM_REG_POINT       = 8'h04;
  localparam logic [7:0] CSM_REG_STATION     = 8'h05;
  localparam logic [7:0] CSM_REG_RATE        = 8'h06;
  localparam logic [7:0] CSM_REG_PERMIT      = 8'h07;
  localparam logic [7:0] CSM_REG_GAP         = 8'h08;
  localparam logic [7:0] CSM_REG_REPLY       = 8'h09;
  localparam logic [7:0] CSM_REG_PASSCODE    = 8'h0a;
  localparam logic [7:0] CSM_REG_UNLOCK      = 8'h0b;
  localparam logic [7:0] CSM_REG_FLAGS       = 8'h0c;
  localparam logic [7:0] CSM_REG_BRIGHT      = 8'h0d;
  localparam logic [7:0] CSM_REG_EDIT        = 8'h0e;
  localparam logic [7:0] CSM_REG_RESTORE     = 8'h0f;
  localparam logic [7:0] CSM_REG_STATUS      = 8'h10;
  localparam logic [7:0] CSM_REG_SCALE_IN    = 8'h11;
  localparam logic [7:0] CSM_REG_SCALE_OUT   = 8'h12;

  // Serial map window that the write permit never blocks
  localparam logic [7:0] CSM_OPEN_LO         = 8'h05;
  localparam logic [7:0] CSM_OPEN_HI         = 8'h0e;

  // ------------------------------------------------------------
  // Ranges and reset values
  // ------------------------------------------------------------
  localparam int         CSM_SETS            = 4;
  localparam logic signed [31:0] CSM_MUL_MIN = -32'sd999999;
  localparam logic signed [31:0] CSM_MUL_MAX = 32'sd9999999;
  localparam logic [31:0] CSM_DEN_MIN        = 32'd1;
  localparam logic [31:0] CSM_DEN_MAX        = 32'd999999;
  localparam logic signed [31:0] CSM_SHF_MIN = -32'sd99999;
  localparam logic signed [31:0] CSM_SHF_MAX = 32'sd999999;
  localparam logic [2:0]  CSM_POINT_MAX      = 3'd5;
  localparam logic [7:0]  CSM_STATION_MAX    = 8'd199;
  localparam logic [7:0]  CSM_ALIAS_ADDR     = 8'hff;
  localparam logic [6:0]  CSM_GAP_MAX        = 7'd99;
  localparam logic [15:0] CSM_PASS_MAX       = 16'd9999;
  localparam logic [15:0] CSM_PASS_OFF       = 16'd0;
  localparam logic [15:0] CSM_RESTORE_CODE   = 16'd5465;
  localparam logic [3:0]  CSM_BRIGHT_MIN     = 4'd1;
  localparam logic [3:0]  CSM_BRIGHT_MAX     = 4'd8;

  localparam logic signed [31:0] CSM_RST_MUL = 32'sd1;
  localparam logic [31:0] CSM_RST_DEN        = 32'd1;
  localparam logic signed [31:0] CSM_RST_SHF = 32'sd0;
  localparam logic [7:0]  CSM_RST_STATION    = 8'd1;
  localparam logic [2:0]  CSM_RST_RATE       = 3'd3;
  localparam logic [3:0]  CSM_RST_BRIGHT     = 4'd8;

  // Restore confirmation command codes
  localparam logic [1:0]  CSM_CMD_CONFIRM    = 2'b01;
  localparam logic [1:0]  CSM_CMD_ESCAPE     = 2'b10;

  // ------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------
  localparam longint      CSM_CLK_HZ         = 250_000_000;
  localparam int          CSM_BITS_PER_CHAR  = 11;
  localparam longint      CSM_CLK_PER_SEC    = CSM_CLK_HZ;

  // Line rates in order of the selector
  localparam int CSM_RATE_BPS [8] = '{1200, 2400, 4800, 9600, 19200, 38400, 57600, 115200};
  // Reply delay choices in character times
  localparam int CSM_REPLY_CHARS [6] = '{0, 10, 20, 50, 100, 200};

  typedef enum logic [1:0] {CSM_RS_IDLE, CSM_RS_ARMED, CSM_RS_CONFIRM} csm_restore_e;

endpackage : csm_pkg

// >>> rtl/csm_setup.sv
// Scaling sets, serial setup, passcode guard and factory restore of the counter instrument
// Functional notes
// - Four scaling sets kept; only the chosen active set is editable.
// - Multiplier accepts -999999 up to 9999999.
// - Denominator 1..999999 sets terminal count of a dividing modulo counter.
// - An all-zero denominator entry is rejected.
// - Shift accepts -99999 up to 999999.
// - Scaling uses fixed point, remainder truncated downward.
// - Station number 0..199; frames to the station are answered.
// - Station zero answers frames addressed 255 instead.
// - Eight line rates from 1200 up to 115200 bit/s.
// - Permit off refuses serial configuration writes; on accepts them.
// - Serial access to 05h..0Eh always allowed.
// - Frame gap timeout 0..99 s; zero turns supervision off.
// - Reply delay none or 10, 20, 50, 100, 200 character times.
// - Four-digit passcode; zero turns menu protection off.
// - Recovery code unlocks once, then dies and zeroes passcode.
// - Per relay flag allows threshold edits without passcode.
// - Flag allows switching the active set without passcode.
// - Display intensity in eight steps, 1 to 8.
// - Entry style: digit by digit or continuous ramp.
// - Restore needs code 5465, then confirm reloads, escape abandons.
//
// Chosen here: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps

module csm_setup
  import csm_pkg::*;
#(
  parameter logic [15:0] RECOVERY_CODE = 16'd1234, // arbitrary value
  parameter longint      CLK_HZ        = CSM_CLK_HZ
) (
  // Clock and reset
  input  wire logic               clk,
  input  wire logic               rst_n,
  // Register port
  input  wire logic [7:0]         reg_addr,
  input  wire logic [31:0]        reg_wdata,
  input  wire logic               reg_wr,
  input  wire logic               reg_rd,
  input  wire logic               reg_remote,
  output logic      [31:0]        reg_rdata,
  // Count input and scaling output
  input  wire logic               count_pulse,
  output logic                    div_tick,
  output logic signed [31:0]      scaled_value,
  output logic      [2:0]         point_pos,
  // Serial link supervision
  input  wire logic               frame_valid,
  input  wire logic [7:0]         frame_addr,
  output logic                    frame_accept,
  output logic                    frame_gap_expired,
  output logic      [2:0]         line_rate_sel,
  output logic                    char_tick,
  output logic                    reply_ready,
  // Panel side
  output logic                    menu_unlocked,
  output logic      [3:0]         threshold_edit_without_passcode,
  output logic                    set_switch_without_passcode,
  output logic      [3:0]         brightness,
  output logic                    ramp_entry,
  output logic                    write_refused
);

  // ------------------------------------------------------------
  // Storage
  // ------------------------------------------------------------
  logic        [1:0]  active_scaling_set;
  logic signed [31:0] mul_q   [CSM_SETS];
  logic        [31:0] den_q   [CSM_SETS];
  logic signed [31:0] shf_q   [CSM_SETS];
  logic        [2:0]  pnt_q   [CSM_SETS];
  logic        [7:0]  station;
  logic               remote_config_write_permit;
  logic        [6:0]  frame_gap_timeout;
  logic        [2:0]  reply_extra_delay;
  logic        [15:0] user_passcode;
  logic               recovery_spent;
  csm_restore_e       restore_state;
  logic               do_restore;
  logic        [31:0] raw_count;
  logic        [31:0] mod_count;
  logic signed [63:0] product;

  // Range test for signed words
  function automatic logic in_range(input logic signed [31:0] v, input logic signed [31:0] lo,
                                    input logic signed [31:0] hi);
    in_range = (v >= lo) && (v <= hi);
  endfunction

  // Clock range the dividers can serve
  if (CLK_HZ > 268435456 || CLK_HZ * CSM_BITS_PER_CHAR < CSM_RATE_BPS[7]) begin : g_clk_chk
    $error("CLK_HZ out of range");
  end

  // ------------------------------------------------------------
  // Write gating
  // ------------------------------------------------------------
  // Remote writes outside the open window need the permit
  logic open_window;
  logic wr_ok;
  assign open_window   = (reg_addr >= CSM_OPEN_LO) && (reg_addr <= CSM_OPEN_HI);
  assign wr_ok         = reg_wr && (!reg_remote || remote_config_write_permit || open_window);
  assign write_refused = reg_wr && !wr_ok;

  // Passcode unlock and one-use recovery
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      menu_unlocked  <= 1'b0;
      recovery_spent <= 1'b0;
    end else if (wr_ok && reg_addr == CSM_REG_UNLOCK) begin
      if (!recovery_spent && reg_wdata[15:0] == RECOVERY_CODE) begin
        menu_unlocked  <= 1'b1;
        recovery_spent <= 1'b1;
      end else begin
        menu_unlocked <= (reg_wdata[15:0] == user_passcode);
      end
    end
  end

  // Panel-side edits need the menu open unless the passcode is off
  logic guard_ok;
  assign guard_ok = reg_remote || menu_unlocked || (user_passcode == CSM_PASS_OFF);

  // ------------------------------------------------------------
  // Scaling sets
  // ------------------------------------------------------------
  // Only the active set is touched; range violations are dropped
  always_ff @(posedge clk) begin
    if (!rst_n || do_restore) begin
      for (int i = 0; i < CSM_SETS; i++) begin
        mul_q[i] <= CSM_RST_MUL;
        den_q[i] <= CSM_RST_DEN;
        shf_q[i] <= CSM_RST_SHF;
        pnt_q[i] <= 3'd0;
      end
    end else if (wr_ok && guard_ok) begin
      unique case (reg_addr)
        CSM_REG_MUL:
          if (in_range(reg_wdata, CSM_MUL_MIN, CSM_MUL_MAX)) mul_q[active_scaling_set] <= reg_wdata;
        CSM_REG_DEN:
          if (reg_wdata >= CSM_DEN_MIN && reg_wdata <= CSM_DEN_MAX) den_q[active_scaling_set] <= reg_wdata;
        CSM_REG_SHIFT:
          if (in_range(reg_wdata, CSM_SHF_MIN, CSM_SHF_MAX)) shf_q[active_scaling_set] <= reg_wdata;
        CSM_REG_POINT:
          if (reg_wdata[2:0] <= CSM_POINT_MAX && reg_wdata[31:3] == '0) pnt_q[active_scaling_set] <= reg_wdata[2:0];
        default: ;
      endcase
    end
  end

  // Active set choice, optionally free of the passcode
  always_ff @(posedge clk) begin
    if (!rst_n || do_restore) begin
      active_scaling_set <= 2'd0;
    end else if (wr_ok && reg_addr == CSM_REG_SET_SEL && (guard_ok || set_switch_without_passcode)) begin
      active_scaling_set <= reg_wdata[1:0];
    end
  end

  // ------------------------------------------------------------
  // Serial and panel settings
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n || do_restore) begin
      station                         <= CSM_RST_STATION;
      line_rate_sel                   <= CSM_RST_RATE;
      remote_config_write_permit      <= 1'b0;
      frame_gap_timeout               <= 7'd0;
      reply_extra_delay               <= 3'd0;
      user_passcode                   <= CSM_PASS_OFF;
      threshold_edit_without_passcode <= 4'h0;
      set_switch_without_passcode     <= 1'b0;
      brightness                      <= CSM_RST_BRIGHT;
      ramp_entry                      <= 1'b0;
    end else if (wr_ok && reg_addr == CSM_REG_UNLOCK && !recovery_spent && reg_wdata[15:0] == RECOVERY_CODE) begin
      user_passcode <= CSM_PASS_OFF;
    end else if (wr_ok && guard_ok) begin
      unique case (reg_addr)
        CSM_REG_STATION:  if (reg_wdata[7:0] <= CSM_STATION_MAX) station <= reg_wdata[7:0];
        CSM_REG_RATE:     line_rate_sel <= reg_wdata[2:0];
        CSM_REG_PERMIT:   remote_config_write_permit <= reg_wdata[0];
        CSM_REG_GAP:      if (reg_wdata[6:0] <= CSM_GAP_MAX) frame_gap_timeout <= reg_wdata[6:0];
        CSM_REG_REPLY:    if (reg_wdata[2:0] <= 3'd5) reply_extra_delay <= reg_wdata[2:0];
        CSM_REG_PASSCODE: if (reg_wdata[15:0] <= CSM_PASS_MAX) user_passcode <= reg_wdata[15:0];
        CSM_REG_FLAGS: begin
          threshold_edit_without_passcode <= reg_wdata[3:0];
          set_switch_without_passcode     <= reg_wdata[4];
        end
        CSM_REG_BRIGHT:
          if (reg_wdata[3:0] >= CSM_BRIGHT_MIN && reg_wdata[3:0] <= CSM_BRIGHT_MAX) brightness <= reg_wdata[3:0];
        CSM_REG_EDIT:     ramp_entry <= reg_wdata[0];
        default: ;
      endcase
    end
  end

  // ------------------------------------------------------------
  // Factory restore sequence
  // ------------------------------------------------------------
  // Code arms, then confirm reloads or escape drops back
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      restore_state <= CSM_RS_IDLE;
    end else if (wr_ok && reg_addr == CSM_REG_RESTORE) begin
      unique case (restore_state)
        CSM_RS_IDLE:    if (reg_wdata[15:0] == CSM_RESTORE_CODE) restore_state <= CSM_RS_CONFIRM;
        CSM_RS_ARMED:   restore_state <= CSM_RS_CONFIRM;
        CSM_RS_CONFIRM: if (reg_wdata[1:0] == CSM_CMD_CONFIRM || reg_wdata[1:0] == CSM_CMD_ESCAPE)
                          restore_state <= CSM_RS_IDLE;
      endcase
    end
  end
  assign do_restore = wr_ok && reg_addr == CSM_REG_RESTORE && restore_state == CSM_RS_CONFIRM
                      && reg_wdata[1:0] == CSM_CMD_CONFIRM;

  // ------------------------------------------------------------
  // Count division and scaling
  // ------------------------------------------------------------
  // Modulo counter wraps at the active denominator
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      mod_count <= 32'd0;
      raw_count <= 32'd0;
      div_tick  <= 1'b0;
    end else begin
      div_tick <= 1'b0;
      if (count_pulse) begin
        raw_count <= raw_count + 32'd1;
        if (mod_count + 32'd1 >= den_q[active_scaling_set]) begin
          mod_count <= 32'd0;
          div_tick  <= 1'b1;
        end else begin
          mod_count <= mod_count + 32'd1;
        end
      end
    end
  end

  // Floor division keeps the truncation downward for negatives too
  logic signed [63:0] quot;
  logic signed [63:0] rem;
  assign product = $signed({32'd0, raw_count}) * 64'(mul_q[active_scaling_set]);
  assign quot    = product / $signed({32'd0, den_q[active_scaling_set]});
  assign rem     = product % $signed({32'd0, den_q[active_scaling_set]});
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      scaled_value <= 32'sd0;
      point_pos    <= 3'd0;
    end else begin
      scaled_value <= 32'(quot - ((rem < 0) ? 64'sd1 : 64'sd0) + 64'(shf_q[active_scaling_set]));
      point_pos    <= pnt_q[active_scaling_set];
    end
  end

  // ------------------------------------------------------------
  // Frame address match and gap supervision
  // ------------------------------------------------------------
  // Station zero takes the alias address
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      frame_accept <= 1'b0;
    end else begin
      frame_accept <= frame_valid && ((station == 8'd0) ? (frame_addr == CSM_ALIAS_ADDR)
                                                          : (frame_addr == station));
    end
  end

  // One-second enable, then seconds counted since last frame
  logic [27:0] sec_div;
  logic [6:0]  gap_secs;
  always_ff @(posedge clk) begin
    if (!rst_n || frame_valid) begin
      sec_div           <= 28'd0;
      gap_secs          <= 7'd0;
      frame_gap_expired <= 1'b0;
    end else if (frame_gap_timeout == 7'd0) begin
      frame_gap_expired <= 1'b0;
    end else if (sec_div == 28'(CLK_HZ - 1)) begin
      sec_div <= 28'd0;
      if (gap_secs + 7'd1 >= frame_gap_timeout) frame_gap_expired <= 1'b1;
      else gap_secs <= gap_secs + 7'd1;
    end else begin
      sec_div <= sec_div + 28'd1;
    end
  end

  // ------------------------------------------------------------
  // Reply delay in character times
  // ------------------------------------------------------------
  // Character tick from the selected rate, chars counted after a match
  logic [23:0] char_div;
  logic [23:0] char_len;
  logic [7:0]  chars_left;
  assign char_len = 24'((CLK_HZ * CSM_BITS_PER_CHAR) / CSM_RATE_BPS[line_rate_sel]);
  always_ff @(posedge clk) begin
    if (!rst_n || char_div + 24'd1 >= char_len) char_div <= 24'd0;
    else char_div <= char_div + 24'd1;
  end
  assign char_tick = (char_div + 24'd1 >= char_len);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      chars_left  <= 8'd0;
      reply_ready <= 1'b0;
    end else if (frame_accept) begin
      chars_left  <= 8'(CSM_REPLY_CHARS[reply_extra_delay]);
      reply_ready <= (reply_extra_delay == 3'd0);
    end else if (chars_left != 8'd0) begin
      reply_ready <= 1'b0;
      if (char_tick) begin
        chars_left <= chars_left - 8'd1;
        if (chars_left == 8'd1) reply_ready <= 1'b1;
      end
    end else begin
      reply_ready <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // Read data, one cycle after the strobe
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      reg_rdata <= 32'h0000_0000;
    end else if (reg_rd) begin
      unique case (reg_addr)
        CSM_REG_SET_SEL:   reg_rdata <= {30'd0, active_scaling_set};
        CSM_REG_MUL:       reg_rdata <= mul_q[active_scaling_set];
        CSM_REG_DEN:       reg_rdata <= den_q[active_scaling_set];
        CSM_REG_SHIFT:     reg_rdata <= shf_q[active_scaling_set];
        CSM_REG_POINT:     reg_rdata <= {29'd0, pnt_q[active_scaling_set]};
        CSM_REG_STATION:   reg_rdata <= {24'd0, station};
        CSM_REG_RATE:      reg_rdata <= {29'd0, line_rate_sel};
        CSM_REG_PERMIT:    reg_rdata <= {31'd0, remote_config_write_permit};
        CSM_REG_GAP:       reg_rdata <= {25'd0, frame_gap_timeout};
        CSM_REG_REPLY:     reg_rdata <= {29'd0, reply_extra_delay};
        CSM_REG_FLAGS:     reg_rdata <= {27'd0, set_switch_without_passcode, threshold_edit_without_passcode};
        CSM_REG_BRIGHT:    reg_rdata <= {28'd0, brightness};
        CSM_REG_EDIT:      reg_rdata <= {31'd0, ramp_entry};
        CSM_REG_STATUS:    reg_rdata <= {26'd0, restore_state == CSM_RS_CONFIRM, recovery_spent,
                                         menu_unlocked, frame_gap_expired, user_passcode != CSM_PASS_OFF, 1'b0};
        CSM_REG_SCALE_IN:  reg_rdata <= raw_count;
        CSM_REG_SCALE_OUT: reg_rdata <= scaled_value;
        default:           reg_rdata <= 32'h0000_0000;
      endcase
    end
  end

endmodule // csm_setup

// >>> test/csm_master_model.sv
// Behavioural serial master handing decoded request frames to the block
`timescale 1ns/1ps

module csm_master_model (
  // Clock
  input  wire logic       clk,
  // Decoded frame strobe and address
  output logic            frame_valid,
  output logic [7:0]      frame_addr
);
  initial begin
    frame_valid = 1'b0;
    frame_addr  = 8'h5a;
  end

  // One frame a call; released address shows its inverse so a stale value never matches
  // Frames come only when the bench calls; the model waits for no reply and keeps to no gap limit
  task automatic send(input logic [7:0] a);
    @(posedge clk);
    frame_valid <= 1'b1;
    frame_addr  <= a;
    @(posedge clk);
    frame_valid <= 1'b0;
    frame_addr  <= ~a;
  endtask
endmodule // csm_master_model

// >>> test/csm_setup_checker.sv
// Port-level assertion checker for the scaling and serial setup block
`timescale 1ns/1ps

module csm_setup_checker
  import csm_pkg::*;
(
  // Clock, reset and register port
  input wire logic       clk,
  input wire logic       rst_n,
  input wire logic [7:0] reg_addr,
  input wire logic       reg_wr,
  input wire logic       reg_remote,
  input wire logic       write_refused,
  // Counting and panel
  input wire logic       count_pulse,
  input wire logic       div_tick,
  input wire logic [2:0] point_pos,
  input wire logic [3:0] brightness,
  // Serial link
  input wire logic       frame_valid,
  input wire logic [7:0] frame_addr,
  input wire logic       frame_accept,
  input wire logic       frame_gap_expired
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // Window of the serial map that the permit never closes
  logic open_win;
  assign open_win = (reg_addr >= CSM_OPEN_LO) && (reg_addr <= CSM_OPEN_HI);

  a_refuse_cause: assert property (write_refused |-> reg_wr && reg_remote && !open_win)
    else $error("refusal without a remote write outside the open window");
  a_open_window: assert property (reg_wr && reg_remote && open_win |-> !write_refused)
    else $error("remote write inside the open window refused");
  a_bright_range: assert property (brightness >= CSM_BRIGHT_MIN && brightness <= CSM_BRIGHT_MAX)
    else $error("intensity outside one to eight");
  a_point_range: assert property (point_pos <= CSM_POINT_MAX)
    else $error("decimal place out of range");
  a_accept_cause: assert property (frame_accept |-> $past(frame_valid))
    else $error("frame accepted without a frame one cycle before");
  a_alias_only: assert property (frame_valid && frame_addr == 8'h00 |=> !frame_accept)
    else $error("frame to address zero accepted");
  a_station_limit: assert property (frame_valid && frame_addr > CSM_STATION_MAX && frame_addr != CSM_ALIAS_ADDR
    |=> !frame_accept)
    else $error("frame above the station range accepted");
  a_gap_cleared: assert property (frame_valid |=> !frame_gap_expired)
    else $error("gap flag still set after a frame");
  a_tick_cause: assert property (div_tick |-> $past(count_pulse))
    else $error("divider wrap without a count");
endmodule // csm_setup_checker

bind csm_setup csm_setup_checker u_chk (.clk, .rst_n, .reg_addr, .reg_wr, .reg_remote, .write_refused,
  .count_pulse, .div_tick, .point_pos, .brightness, .frame_valid, .frame_addr, .frame_accept, .frame_gap_expired);

// >>> test/tb_top.sv
// Self-checking bench of the scaling and serial setup block
`timescale 1ns/1ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin mismatches++; \
  $display("MISMATCH t=%0t got=%0h exp=%0h", $time, g, e); end end

module tb_top
  import csm_pkg::*;
;
  logic               clk, rst_n, reg_wr, reg_rd, reg_remote, count_pulse, refused;
  logic        [7:0]  reg_addr, frame_addr;
  logic        [31:0] reg_wdata, reg_rdata, d;
  logic signed [31:0] scaled_value;
  logic        [2:0]  point_pos, line_rate_sel;
  logic        [3:0]  threshold_edit_without_passcode, brightness;
  logic               div_tick, frame_valid, frame_accept, frame_gap_expired, char_tick, reply_ready;
  logic               menu_unlocked, set_switch_without_passcode, ramp_entry, write_refused;
  int                 mismatches, n_checks, ticks;

  csm_setup #(.CLK_HZ(12000)) u_dut (.clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_remote,
    .reg_rdata, .count_pulse, .div_tick, .scaled_value, .point_pos, .frame_valid, .frame_addr, .frame_accept,
    .frame_gap_expired, .line_rate_sel, .char_tick, .reply_ready, .menu_unlocked,
    .threshold_edit_without_passcode, .set_switch_without_passcode, .brightness, .ramp_entry, .write_refused);
  csm_master_model m (.clk, .frame_valid, .frame_addr);

  // -----------------------------------------------------------
  // Bus tasks: strobe one cycle, settle before any look
  // -----------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic rem = 1'b0);
    @(posedge clk);
    reg_addr   <= a;
    reg_wdata  <= v;
    reg_remote <= rem;
    reg_wr     <= 1'b1;
    @(negedge clk);
    refused = write_refused;
    @(posedge clk);
    reg_wr <= 1'b0;
    @(negedge clk);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    v = reg_rdata;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] v;
    rd(a, v);
    `CHK(v, e)
  endtask
  // Legal value lands, the out-of-range one after it is dropped
  task automatic bound(input logic [7:0] a, input logic [31:0] good, input logic [31:0] bad);
    wr(a, good);
    wr(a, bad);
    rdc(a, good);
  endtask
  task automatic frm(input logic [7:0] a, input logic acc, input logic rep);
    m.send(a);
    @(negedge clk);
    `CHK(frame_accept, acc)
    @(negedge clk);
    `CHK(reply_ready, rep)
  endtask

  // -----------------------------------------------------------
  // Scenarios
  // -----------------------------------------------------------
  task automatic t_reset;
    `CHK(brightness, 4'h8)
    `CHK(line_rate_sel, 3'h3)
    rdc(CSM_REG_STATION, 32'h1);
    for (int i = 0; i < 8; i++) begin
      wr(CSM_REG_RATE, 32'(i));
      `CHK(line_rate_sel, 3'(i))
    end
  endtask
  task automatic t_scale;
    wr(CSM_REG_MUL, -32'sd3);
    wr(CSM_REG_DEN, 32'h2);
    wr(CSM_REG_POINT, 32'h2);
    repeat (7) begin
      @(posedge clk) count_pulse <= 1'b1;
      @(posedge clk) count_pulse <= 1'b0;
    end
    repeat (3) @(negedge clk);
    `CHK(scaled_value, -32'sd11)
    `CHK(ticks, 3)
    `CHK(point_pos, 3'h2)
    rdc(CSM_REG_SCALE_IN, 32'h7);
    wr(CSM_REG_SET_SEL, 32'h1);
    rdc(CSM_REG_MUL, 32'h1);
    `CHK(point_pos, 3'h0)
  endtask
  task automatic t_bounds;
    bound(CSM_REG_MUL, 32'd9999999, 32'd10000000);
    bound(CSM_REG_MUL, -32'sd999999, -32'sd1000000);
    bound(CSM_REG_DEN, 32'd999999, 32'd1000000);
    bound(CSM_REG_DEN, 32'd1, 32'd0);
    bound(CSM_REG_SHIFT, -32'sd99999, -32'sd100000);
    bound(CSM_REG_SHIFT, 32'd999999, 32'd1000000);
    bound(CSM_REG_GAP, 32'd99, 32'd100);
    bound(CSM_REG_REPLY, 32'd5, 32'd6);
    bound(CSM_REG_BRIGHT, 32'd1, 32'd0);
    bound(CSM_REG_BRIGHT, 32'd8, 32'd9);
    wr(CSM_REG_SET_SEL, 32'h0);
    rdc(CSM_REG_MUL, -32'sd3);
  endtask
  task automatic t_link;
    wr(CSM_REG_REPLY, 32'h0);
    wr(CSM_REG_STATION, 32'h0);
    frm(8'hff, 1'b1, 1'b1);
    frm(8'h00, 1'b0, 1'b0);
    bound(CSM_REG_STATION, 32'd199, 32'd200);
    frm(8'hc7, 1'b1, 1'b1);
    frm(8'hc8, 1'b0, 1'b0);
    frm(8'hff, 1'b0, 1'b0);
    wr(CSM_REG_REPLY, 32'h1);
    frm(8'hc7, 1'b1, 1'b0);
    repeat (10) @(negedge clk);
    `CHK(reply_ready, 1'b1)
  endtask
  task automatic t_permit;
    wr(CSM_REG_MUL, 32'h7, 1'b1);
    `CHK(refused, 1'b1)
    rdc(CSM_REG_MUL, -32'sd3);
    wr(CSM_REG_BRIGHT, 32'h5, 1'b1);
    `CHK(refused, 1'b0)
    `CHK(brightness, 4'h5)
    wr(CSM_REG_PERMIT, 32'h1);
    wr(CSM_REG_MUL, 32'h7, 1'b1);
    `CHK(refused, 1'b0)
    rdc(CSM_REG_MUL, 32'h7);
  endtask
  task automatic t_panel;
    wr(CSM_REG_FLAGS, 32'h1a);
    `CHK(threshold_edit_without_passcode, 4'ha)
    `CHK(set_switch_without_passcode, 1'b1)
    wr(CSM_REG_EDIT, 32'h1);
    `CHK(ramp_entry, 1'b1)
    wr(CSM_REG_EDIT, 32'h0);
    `CHK(ramp_entry, 1'b0)
  endtask
  task automatic t_gap;
    wr(CSM_REG_GAP, 32'h1);
    frm(8'hc7, 1'b1, 1'b0);
    repeat (11990) @(negedge clk);
    `CHK(frame_gap_expired, 1'b0)
    repeat (20) @(negedge clk);
    `CHK(frame_gap_expired, 1'b1)
    wr(CSM_REG_GAP, 32'h0);
    @(negedge clk);
    `CHK(frame_gap_expired, 1'b0)
  endtask
  task automatic t_restore;
    wr(CSM_REG_BRIGHT, 32'h3);
    wr(CSM_REG_RESTORE, 32'd5464);
    wr(CSM_REG_RESTORE, 32'h1);
    `CHK(brightness, 4'h3)
    wr(CSM_REG_RESTORE, 32'd5465);
    rd(CSM_REG_STATUS, d);
    `CHK(d[5], 1'b1)
    wr(CSM_REG_RESTORE, 32'h2);
    `CHK(brightness, 4'h3)
    wr(CSM_REG_RESTORE, 32'd5465);
    wr(CSM_REG_RESTORE, 32'h1);
    `CHK(brightness, 4'h8)
    rdc(CSM_REG_STATION, 32'h1);
  endtask
  task automatic t_lock;
    wr(CSM_REG_FLAGS, 32'h10);
    wr(CSM_REG_PASSCODE, 32'd4321);
    wr(CSM_REG_BRIGHT, 32'h2);
    `CHK(brightness, 4'h8)
    wr(CSM_REG_SET_SEL, 32'h2);
    rdc(CSM_REG_SET_SEL, 32'h2);
    wr(CSM_REG_UNLOCK, 32'd1234);
    `CHK(menu_unlocked, 1'b1)
    rd(CSM_REG_STATUS, d);
    `CHK(d[1], 1'b0)
    `CHK(d[4], 1'b1)
    wr(CSM_REG_PASSCODE, 32'd4321);
    wr(CSM_REG_UNLOCK, 32'd1234);
    `CHK(menu_unlocked, 1'b0)
  endtask

  task automatic summarize;
    $display("checks=%0d mismatches=%0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Clock, wrap counter, watchdog and main sequence
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk) if (div_tick) ticks <= ticks + 1;
  initial begin
    #100000;
    mismatches++;
    summarize;
  end
  initial begin
    {rst_n, reg_wr, reg_rd, reg_remote, count_pulse, reg_addr, reg_wdata} = '0;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    t_reset;
    t_scale;
    t_bounds;
    t_link;
    t_permit;
    t_panel;
    t_gap;
    t_restore;
    t_lock;
    summarize;
  end
endmodule // tb_top
